// >>> rtl/cpusf_params.svh
// Register offsets, field positions, reset values and address-map constants of the status/flags datapath.
`ifndef CPUSF_PARAMS_SVH
`define CPUSF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define CPUSF_OFS_PSW    8'h00
`define CPUSF_OFS_PC     8'h04
`define CPUSF_OFS_ACC    8'h08
`define CPUSF_OFS_TMP    8'h0c
`define CPUSF_OFS_IX     8'h10
`define CPUSF_OFS_EP     8'h14
`define CPUSF_OFS_SP     8'h18
`define CPUSF_OFS_STATUS 8'h1c

// ----------------------------------------------------------------------------
// Condition-code byte field positions
// ----------------------------------------------------------------------------
`define CPUSF_CCR_H  7
`define CPUSF_CCR_I  6
`define CPUSF_CCR_IH 5
`define CPUSF_CCR_IL 4
`define CPUSF_CCR_N  3
`define CPUSF_CCR_Z  2
`define CPUSF_CCR_V  1
`define CPUSF_CCR_C  0

// ----------------------------------------------------------------------------
// Reset values and address map
// ----------------------------------------------------------------------------
`define CPUSF_PSW_RESET 16'h0030
`define CPUSF_REG_RESET 16'h0000
`define CPUSF_GPR_BASE  16'h0100
`define CPUSF_IO_TOP    16'h0080
`define CPUSF_DATA_TOP  16'h0880
`define CPUSF_PROG_BASE 16'h8000

`endif

// >>> rtl/cpusf_pkg.sv
// Types shared by the status/flags datapath modules.
package cpusf_pkg;

  // ALU operations issued by the sequencer.
  typedef enum logic [3:0] {
    CPUSF_OP_ADD, CPUSF_OP_ADDC, CPUSF_OP_SUB, CPUSF_OP_SUBC, CPUSF_OP_CMP,
    CPUSF_OP_AND, CPUSF_OP_OR, CPUSF_OP_XOR, CPUSF_OP_ROLC, CPUSF_OP_RORC
  } cpusf_alu_op_type;

  // Dedicated register selector; the first six index the word-register array.
  typedef enum logic [2:0] {
    CPUSF_SEL_PC, CPUSF_SEL_ACC, CPUSF_SEL_TMP, CPUSF_SEL_IX,
    CPUSF_SEL_EP, CPUSF_SEL_SP, CPUSF_SEL_PSW, CPUSF_SEL_NONE
  } cpusf_reg_sel_type;

  // Region of the 64 KiB address space.
  typedef enum logic [1:0] {
    CPUSF_REGION_IO, CPUSF_REGION_DATA, CPUSF_REGION_GAP, CPUSF_REGION_PROG
  } cpusf_region_type;

endpackage : cpusf_pkg

// >>> rtl/cpusf_reg16.sv
// One 16-bit dedicated register with byte-lane load and increment.
`timescale 1ns/1ps
`include "cpusf_params.svh"
module cpusf_reg16 import cpusf_pkg::*; (
  // Clock and control
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Update requests
  input  wire logic        load_en,
  input  wire logic [1:0]  load_lanes,
  input  wire logic [15:0] load_data,
  input  wire logic        inc,
  // Stored value
  output logic      [15:0] value
);

  typedef struct packed {
    logic [15:0] word;
  } cpusf_reg16_state_type;

  cpusf_reg16_state_type state_reg;
  cpusf_reg16_state_type state_next;

  // ----------------------------------------------------------------------------
  // Next state: a load beats an increment so a jump is never lost.
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (load_en) begin
      if (load_lanes[0]) state_next.word[7:0] = load_data[7:0];
      if (load_lanes[1]) state_next.word[15:8] = load_data[15:8];
    end else if (inc) begin
      state_next.word = state_reg.word + 16'h0001;
    end
  end

  // Registers are cleared for a defined start even where contents are unspecified.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg.word <= `CPUSF_REG_RESET;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg.word;

endmodule : cpusf_reg16

// >>> rtl/cpusf_alu.sv
// Combinational arithmetic unit producing a result and the condition flags.
`timescale 1ns/1ps
module cpusf_alu import cpusf_pkg::*; (
  // Operands
  input  wire logic             [15:0] acc_in,
  input  wire logic             [15:0] tmp_in,
  input  wire logic                    carry_in,
  input  wire cpusf_alu_op_type        op,
  input  wire logic                    wide,
  // Results
  output logic                  [15:0] result,
  output logic                         write_acc,
  output logic                  [4:0]  affect,
  output logic                  [4:0]  flags
);

  logic [16:0] add16;
  logic [16:0] sub16;
  logic [8:0]  add8;
  logic [8:0]  sub8;
  logic [4:0]  hadd;
  logic [4:0]  hsub;
  logic        cin;
  logic        is_sub;
  logic        carry;
  logic        a_msb;
  logic        t_msb;
  logic        r_msb;

  // ----------------------------------------------------------------------------
  // Flags are packed as {H, N, Z, V, C}; affect marks which ones the op updates.
  // ----------------------------------------------------------------------------
  always_comb begin
    cin    = (op == CPUSF_OP_ADDC || op == CPUSF_OP_SUBC) ? carry_in : 1'b0;
    is_sub = (op == CPUSF_OP_SUB || op == CPUSF_OP_SUBC || op == CPUSF_OP_CMP);
    add16  = {1'b0, acc_in} + {1'b0, tmp_in} + {16'h0000, cin};
    sub16  = {1'b0, acc_in} - {1'b0, tmp_in} - {16'h0000, cin};
    add8   = {1'b0, acc_in[7:0]} + {1'b0, tmp_in[7:0]} + {8'h00, cin};
    sub8   = {1'b0, acc_in[7:0]} - {1'b0, tmp_in[7:0]} - {8'h00, cin};
    hadd   = {1'b0, acc_in[3:0]} + {1'b0, tmp_in[3:0]} + {4'h0, cin};
    hsub   = {1'b0, acc_in[3:0]} - {1'b0, tmp_in[3:0]} - {4'h0, cin};
    result    = acc_in;
    carry     = carry_in;
    write_acc = 1'b1;
    affect    = 5'h00;
    case (op)
      CPUSF_OP_ADD, CPUSF_OP_ADDC, CPUSF_OP_SUB, CPUSF_OP_SUBC, CPUSF_OP_CMP: begin
        // Byte operations leave the upper accumulator byte alone.
        if (wide) begin
          result = is_sub ? sub16[15:0] : add16[15:0];
          carry  = is_sub ? sub16[16] : add16[16];
        end else begin
          result = {acc_in[15:8], (is_sub ? sub8[7:0] : add8[7:0])};
          carry  = is_sub ? sub8[8] : add8[8];
        end
        write_acc = (op != CPUSF_OP_CMP);
        affect    = 5'h1f;
      end
      CPUSF_OP_AND: begin
        result = wide ? (acc_in & tmp_in) : {acc_in[15:8], acc_in[7:0] & tmp_in[7:0]};
        affect = 5'h0c;
      end
      CPUSF_OP_OR: begin
        result = wide ? (acc_in | tmp_in) : {acc_in[15:8], acc_in[7:0] | tmp_in[7:0]};
        affect = 5'h0c;
      end
      CPUSF_OP_XOR: begin
        result = wide ? (acc_in ^ tmp_in) : {acc_in[15:8], acc_in[7:0] ^ tmp_in[7:0]};
        affect = 5'h0c;
      end
      CPUSF_OP_ROLC: begin
        // The bit shifted out lands in carry.
        result = wide ? {acc_in[14:0], carry_in} : {acc_in[15:8], acc_in[6:0], carry_in};
        carry  = wide ? acc_in[15] : acc_in[7];
        affect = 5'h0d;
      end
      CPUSF_OP_RORC: begin
        result = wide ? {carry_in, acc_in[15:1]} : {acc_in[15:8], carry_in, acc_in[7:1]};
        carry  = acc_in[0];
        affect = 5'h0d;
      end
      default: begin
        write_acc = 1'b0;
      end
    endcase
    a_msb = wide ? acc_in[15] : acc_in[7];
    t_msb = wide ? tmp_in[15] : tmp_in[7];
    r_msb = wide ? result[15] : result[7];
    flags[4] = is_sub ? hsub[4] : hadd[4];
    flags[3] = r_msb;
    flags[2] = wide ? (result == 16'h0000) : (result[7:0] == 8'h00);
    flags[1] = is_sub ? (a_msb != t_msb) && (r_msb != a_msb)
                      : (a_msb == t_msb) && (r_msb != a_msb);
    flags[0] = carry;
  end

endmodule : cpusf_alu

// >>> rtl/cpusf_core.sv
// Dedicated registers, program status word and flag logic of the core, with an Avalon-MM register port.
//
// Functional notes
// - A 16-bit status word: upper byte is bank pointer, lower byte condition codes.
// - A 16-bit program counter holds the address of the instruction being fetched.
// - A 16-bit accumulator takes results; byte operations use its low byte only.
// - A 16-bit temporary accumulator is second operand; byte operations use low byte.
// - Index register, extra pointer and stack pointer are each 16 bits.
// - Half-carry tracks carry or borrow between bit 3 and bit 4.
// - Interrupts pass only while interrupt enable is 1; reset clears it.
// - Two-bit level mask: serve request only when its level beats the mask.
// - Negative flag copies the most significant result bit.
// - Zero flag is set exactly when the result is zero.
// - Overflow flag reports two's-complement overflow.
// - Carry reports carry or borrow out of the top bit; shifts load shifted-out bit.
// - One 64 KiB space: I/O lowest, data above, program area at the top.
// - Bank pointer picks one of 32 banks of eight byte registers.
//
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "cpusf_params.svh"
module cpusf_core import cpusf_pkg::*; #(
  parameter logic [15:0] GPR_BASE  = `CPUSF_GPR_BASE,
  parameter logic [15:0] IO_TOP    = `CPUSF_IO_TOP,
  parameter logic [15:0] DATA_TOP  = `CPUSF_DATA_TOP,
  parameter logic [15:0] PROG_BASE = `CPUSF_PROG_BASE
) (
  // Clock, reset and enable
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // Avalon-MM slave
  input  wire logic        [7:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic       [31:0] avs_writedata,
  input  wire logic        [3:0] avs_byteenable,
  output logic            [31:0] avs_readdata,
  output logic                   avs_waitrequest,
  // Sequencer: ALU operation
  input  wire logic              alu_valid,
  input  wire cpusf_alu_op_type  alu_op,
  input  wire logic              alu_wide,
  // Sequencer: register write and program counter
  input  wire logic              reg_wr_valid,
  input  wire cpusf_reg_sel_type reg_wr_sel,
  input  wire logic       [15:0] reg_wr_data,
  input  wire logic              pc_inc,
  input  wire logic              pc_load,
  input  wire logic       [15:0] pc_load_value,
  // Interrupt request logic
  input  wire logic              irq_request,
  input  wire logic        [1:0] irq_level,
  output logic                   irq_accept,
  // Address helpers
  input  wire logic        [2:0] gp_reg_index,
  output logic            [15:0] gp_reg_addr,
  input  wire logic       [15:0] mem_addr,
  output cpusf_region_type       mem_region,
  // Register values
  output logic            [15:0] program_status_word,
  output logic            [15:0] pc_value,
  output logic            [15:0] acc_value,
  output logic            [15:0] tmp_value,
  output logic            [15:0] index_register,
  output logic            [15:0] extra_pointer,
  output logic            [15:0] sp_value
);

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic [15:0]      psw;
    logic [15:0]      gp_addr;
    cpusf_region_type region;
  } cpusf_core_state_type;

  cpusf_core_state_type state_reg;
  cpusf_core_state_type state_next;

  logic [15:0] word_value [6];
  logic [5:0]  word_load;
  logic [1:0]  word_lanes [6];
  logic [15:0] word_data [6];
  logic [15:0] alu_result;
  logic        alu_write_acc;
  logic [4:0]  alu_affect;
  logic [4:0]  alu_flags;
  logic        bus_req;
  logic        bus_accept;
  logic        bus_wr;
  logic [1:0]  req_rank;
  logic [1:0]  mask_rank;
  logic [7:0]  condition_code_byte;

  assign condition_code_byte = state_reg.psw[7:0];

  // ----------------------------------------------------------------------------
  // Arithmetic unit and word registers
  // ----------------------------------------------------------------------------
  cpusf_alu u_alu (
    .acc_in    (word_value[CPUSF_SEL_ACC]),
    .tmp_in    (word_value[CPUSF_SEL_TMP]),
    .carry_in  (condition_code_byte[`CPUSF_CCR_C]),
    .op        (alu_op),
    .wide      (alu_wide),
    .result    (alu_result),
    .write_acc (alu_write_acc),
    .affect    (alu_affect),
    .flags     (alu_flags)
  );

  // Six identical 16-bit registers: PC, A, T, IX, EP, SP.
  for (genvar g = 0; g < 6; g++) begin : g_word
    cpusf_reg16 u_reg (
      .clock      (clock),
      .rst        (rst),
      .clk_en     (clk_en),
      .load_en    (word_load[g]),
      .load_lanes (word_lanes[g]),
      .load_data  (word_data[g]),
      .inc        ((g == 0) && pc_inc),
      .value      (word_value[g])
    );
  end

  // ----------------------------------------------------------------------------
  // Bus handshake: one wait cycle, then the request is taken.
  // ----------------------------------------------------------------------------
  assign bus_req         = avs_read || avs_write;
  assign bus_accept      = bus_req && state_reg.ack;
  assign bus_wr          = bus_accept && avs_write;
  assign avs_waitrequest = bus_req && !state_reg.ack;
  assign avs_readdata    = state_reg.rdata;

  // Load selection per word register; ALU beats sequencer, sequencer beats bus.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      word_load[i]  = 1'b0;
      word_lanes[i] = 2'b11;
      word_data[i]  = reg_wr_data;
      if (reg_wr_valid && reg_wr_sel == cpusf_reg_sel_type'(i)) begin
        word_load[i] = 1'b1;
      end else if (bus_wr && avs_address == 8'(4 * (i + 1))) begin
        word_load[i]  = |avs_byteenable[1:0];
        word_lanes[i] = avs_byteenable[1:0];
        word_data[i]  = avs_writedata[15:0];
      end
    end
    if (pc_load) begin
      word_load[CPUSF_SEL_PC]  = 1'b1;
      word_lanes[CPUSF_SEL_PC] = 2'b11;
      word_data[CPUSF_SEL_PC]  = pc_load_value;
    end
    if (alu_valid && alu_write_acc) begin
      word_load[CPUSF_SEL_ACC]  = 1'b1;
      word_lanes[CPUSF_SEL_ACC] = alu_wide ? 2'b11 : 2'b01;
      word_data[CPUSF_SEL_ACC]  = alu_result;
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt gate: ranks 1 (high) .. 3 (low); equal rank is not admitted.
  // ----------------------------------------------------------------------------
  assign req_rank   = irq_level[1] ? (irq_level[0] ? 2'h3 : 2'h2) : 2'h1;
  assign mask_rank  = condition_code_byte[`CPUSF_CCR_IH] ? (condition_code_byte[`CPUSF_CCR_IL] ? 2'h3 : 2'h2) : 2'h1;
  assign irq_accept = irq_request && condition_code_byte[`CPUSF_CCR_I] && (req_rank < mask_rank);

  // ----------------------------------------------------------------------------
  // Next state of the status word, read data and address helpers.
  // ----------------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    state_next.ack = bus_req && !state_reg.ack;
    // Status word writes: sequencer over bus; the ALU then overrides touched flags.
    if (reg_wr_valid && reg_wr_sel == CPUSF_SEL_PSW) begin
      state_next.psw = reg_wr_data;
    end else if (bus_wr && avs_address == `CPUSF_OFS_PSW) begin
      if (avs_byteenable[0]) state_next.psw[7:0] = avs_writedata[7:0];
      if (avs_byteenable[1]) state_next.psw[15:8] = avs_writedata[15:8];
    end
    if (alu_valid) begin
      // Untouched flags keep their old value from the status word.
      if (alu_affect[4]) state_next.psw[`CPUSF_CCR_H] = alu_flags[4];
      if (alu_affect[3]) state_next.psw[`CPUSF_CCR_N] = alu_flags[3];
      if (alu_affect[2]) state_next.psw[`CPUSF_CCR_Z] = alu_flags[2];
      if (alu_affect[1]) state_next.psw[`CPUSF_CCR_V] = alu_flags[1];
      if (alu_affect[0]) state_next.psw[`CPUSF_CCR_C] = alu_flags[0];
    end
    // Read data is captured in the wait cycle so it stands on the accepting edge.
    if (avs_read && !state_reg.ack) begin
      case (avs_address)
        `CPUSF_OFS_PSW:    state_next.rdata = {16'h0000, state_reg.psw};
        `CPUSF_OFS_PC:     state_next.rdata = {16'h0000, word_value[CPUSF_SEL_PC]};
        `CPUSF_OFS_ACC:    state_next.rdata = {16'h0000, word_value[CPUSF_SEL_ACC]};
        `CPUSF_OFS_TMP:    state_next.rdata = {16'h0000, word_value[CPUSF_SEL_TMP]};
        `CPUSF_OFS_IX:     state_next.rdata = {16'h0000, word_value[CPUSF_SEL_IX]};
        `CPUSF_OFS_EP:     state_next.rdata = {16'h0000, word_value[CPUSF_SEL_EP]};
        `CPUSF_OFS_SP:     state_next.rdata = {16'h0000, word_value[CPUSF_SEL_SP]};
        `CPUSF_OFS_STATUS: state_next.rdata = {30'h00000000, irq_request, irq_accept};
        default:           state_next.rdata = 32'h00000000;
      endcase
    end
    // Bank base is pointer times eight; only five pointer bits reach 32 banks.
    state_next.gp_addr = GPR_BASE + {8'h00, state_reg.psw[12:8], gp_reg_index};
    // Region order from bottom: I/O, data, unused gap, program.
    if (mem_addr < IO_TOP) begin
      state_next.region = CPUSF_REGION_IO;
    end else if (mem_addr < DATA_TOP) begin
      state_next.region = CPUSF_REGION_DATA;
    end else if (mem_addr < PROG_BASE) begin
      state_next.region = CPUSF_REGION_GAP;
    end else begin
      state_next.region = CPUSF_REGION_PROG;
    end
  end

  // Reset clears interrupt enable and sets the level mask to 3; other contents are zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg.ack     <= 1'b0;
      state_reg.rdata   <= 32'h00000000;
      state_reg.psw     <= `CPUSF_PSW_RESET;
      state_reg.gp_addr <= 16'h0000;
      state_reg.region  <= CPUSF_REGION_IO;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign program_status_word = state_reg.psw;
  assign pc_value            = word_value[CPUSF_SEL_PC];
  assign acc_value           = word_value[CPUSF_SEL_ACC];
  assign tmp_value           = word_value[CPUSF_SEL_TMP];
  assign index_register      = word_value[CPUSF_SEL_IX];
  assign extra_pointer       = word_value[CPUSF_SEL_EP];
  assign sp_value            = word_value[CPUSF_SEL_SP];
  assign gp_reg_addr         = state_reg.gp_addr;
  assign mem_region          = state_reg.region;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic arith_op;
  assign arith_op = alu_op inside {CPUSF_OP_ADD, CPUSF_OP_ADDC, CPUSF_OP_SUB, CPUSF_OP_SUBC};

  ie_gate_a: assert property (irq_accept |-> condition_code_byte[`CPUSF_CCR_I] && irq_request)
    else $error("interrupt accepted while disabled");
  level_mask_a: assert property (irq_level == 2'b11 |-> !irq_accept)
    else $error("lowest level request accepted");
  level_pass_a: assert property (irq_request && condition_code_byte[`CPUSF_CCR_I] && condition_code_byte[5:4] == 2'b10
    && irq_level == 2'b00 |-> irq_accept)
    else $error("level one request refused under level two mask");
  zero_flag_a: assert property (clk_en && alu_valid && arith_op && !reg_wr_valid
    |=> condition_code_byte[`CPUSF_CCR_Z] == ($past(alu_wide) ? (acc_value == 16'h0000) : (acc_value[7:0] == 8'h00)))
    else $error("zero flag disagrees with result");
  neg_flag_a: assert property (clk_en && alu_valid && arith_op && !reg_wr_valid
    |=> condition_code_byte[`CPUSF_CCR_N] == ($past(alu_wide) ? acc_value[15] : acc_value[7]))
    else $error("negative flag disagrees with result");
  half_carry_a: assert property (clk_en && alu_valid && alu_op == CPUSF_OP_ADD
    |=> condition_code_byte[`CPUSF_CCR_H] == ((5'($past(acc_value[3:0])) + 5'($past(tmp_value[3:0]))) > 5'h0f))
    else $error("half carry wrong after add");
  flag_keep_a: assert property (clk_en && alu_valid && alu_op == CPUSF_OP_AND
    && !reg_wr_valid && !bus_wr |=> $stable(condition_code_byte[1:0]) && $stable(condition_code_byte[7:4]))
    else $error("logical op disturbed untouched flags");
  acc_upper_a: assert property (clk_en && alu_valid && !alu_wide && arith_op
    |=> acc_value[15:8] == $past(acc_value[15:8]))
    else $error("byte op changed accumulator upper byte");
  pc_step_a: assert property (clk_en && pc_inc && !pc_load
    && !(reg_wr_valid && reg_wr_sel == CPUSF_SEL_PC) && !bus_wr |=> pc_value == $past(pc_value) + 16'h0001)
    else $error("program counter did not advance");
  bank_addr_a: assert property (clk_en ##1 clk_en
    |=> gp_reg_addr == GPR_BASE + {8'h00, $past(program_status_word[12:8]), $past(gp_reg_index)})
    else $error("bank register address wrong");
  bus_answer_a: assert property (bus_req && clk_en |-> ##[0:1] !avs_waitrequest)
    else $error("bus request not answered within one wait cycle");

  irq_taken_c: cover property (irq_accept);
  bus_write_c: cover property (bus_wr && avs_address == `CPUSF_OFS_PSW);
  carry_add_c: cover property (alu_valid && alu_op == CPUSF_OP_ADDC && condition_code_byte[`CPUSF_CCR_C]);
  shift_out_c: cover property (alu_valid && alu_op == CPUSF_OP_RORC && acc_value[0]);

endmodule : cpusf_core

// >>> test/cpusf_seq_model.sv
// Sequencer stand-in that issues register writes and ALU operations.
`timescale 1ns/1ps
module cpusf_seq_model import cpusf_pkg::*; (
  // Clock
  input  wire logic         clock,
  // Operation issue
  output cpusf_alu_op_type  alu_op,
  output logic              alu_valid,
  output logic              alu_wide,
  // Register write
  output logic              reg_wr_valid,
  output cpusf_reg_sel_type reg_wr_sel,
  output logic       [15:0] reg_wr_data
);
  // Strobes idle low; the core samples them on every enabled edge.
  initial begin
    {alu_valid, alu_wide, reg_wr_valid, reg_wr_data} = '0;
    alu_op = CPUSF_OP_ADD;
    reg_wr_sel = CPUSF_SEL_NONE;
  end
  // One-cycle write pulse; the data bus is inverted on release so stale data never looks valid.
  task automatic wr(input cpusf_reg_sel_type s, input logic [15:0] d);
    @(posedge clock);
    reg_wr_valid <= 1'b1;
    reg_wr_sel <= s;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_valid <= 1'b0;
    reg_wr_data <= ~d;
  endtask : wr
  // One-cycle ALU operation pulse.
  task automatic alu(input cpusf_alu_op_type op, input logic w);
    @(posedge clock);
    alu_valid <= 1'b1;
    alu_op <= op;
    alu_wide <= w;
    @(posedge clock);
    alu_valid <= 1'b0;
  endtask : alu
endmodule : cpusf_seq_model

// >>> test/cpu_status_flags_datapath_test.sv
// Self-checking bench for the status and flags datapath core.
`timescale 1ns/1ps
module cpu_status_flags_datapath_test import cpusf_pkg::*; ;
  typedef struct packed {cpusf_alu_op_type op; logic [7:0] p, a, t, e, c;} cpusf_row_type;
  logic clock = 0, rst = 1, clk_en = 1, avs_read = 0, avs_write = 0, pc_inc = 0, pc_load = 0, irq_request = 0;
  logic [7:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'h3;
  logic [15:0] pc_load_value = '0, mem_addr = '0;
  logic [1:0] irq_level = '0;
  logic [2:0] gp_reg_index = '0;
  logic avs_waitrequest, irq_accept, alu_valid, alu_wide, reg_wr_valid;
  cpusf_alu_op_type alu_op;
  cpusf_reg_sel_type reg_wr_sel;
  cpusf_region_type mem_region;
  logic [15:0] reg_wr_data, gp_reg_addr, program_status_word, pc_value, acc_value, tmp_value;
  logic [15:0] index_register, extra_pointer, sp_value;
  int error_cnt = 0, num_checks = 0;
  // Byte operations: the high byte 8'h12 of the accumulator must survive each one.
  cpusf_row_type rows [13] = '{
    '{CPUSF_OP_ADD, 8'h00, 8'h0f, 8'h01, 8'h10, 8'h80}, '{CPUSF_OP_ADD, 8'h00, 8'h80, 8'h80, 8'h00, 8'h07},
    '{CPUSF_OP_ADD, 8'h00, 8'h7f, 8'h01, 8'h80, 8'h8a}, '{CPUSF_OP_SUB, 8'h00, 8'h10, 8'h01, 8'h0f, 8'h80},
    '{CPUSF_OP_SUB, 8'h00, 8'h00, 8'h01, 8'hff, 8'h89}, '{CPUSF_OP_ADDC, 8'h01, 8'h01, 8'h01, 8'h03, 8'h00},
    '{CPUSF_OP_SUBC, 8'h01, 8'h05, 8'h01, 8'h03, 8'h00}, '{CPUSF_OP_CMP, 8'h00, 8'h05, 8'h05, 8'h05, 8'h04},
    '{CPUSF_OP_AND, 8'h83, 8'hf0, 8'h0f, 8'h00, 8'h87}, '{CPUSF_OP_OR, 8'h00, 8'h01, 8'h80, 8'h81, 8'h08},
    '{CPUSF_OP_XOR, 8'h00, 8'h55, 8'h55, 8'h00, 8'h04}, '{CPUSF_OP_ROLC, 8'h00, 8'h81, 8'h00, 8'h02, 8'h01},
    '{CPUSF_OP_RORC, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05}};
  cpusf_core uut (.*);
  cpusf_seq_model u_seq (.*);
  // Free-running 125 MHz clock.
  always #4 clock = ~clock;
  // Compare and count; case inequality lets no unknown pass.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Avalon transfer held until waitrequest is seen low; read data lands in q.
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(negedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin error_cnt++; final_report(); end
  endtask : bus
  // Load operands and flags, run one operation, then compare result and status word.
  task automatic run(input cpusf_alu_op_type op, input logic w, input logic [7:0] p,
                     input logic [15:0] a, input logic [15:0] t, input logic [15:0] e, input logic [7:0] c);
    u_seq.wr(CPUSF_SEL_ACC, a);
    u_seq.wr(CPUSF_SEL_TMP, t);
    u_seq.wr(CPUSF_SEL_PSW, {8'h00, p});
    u_seq.alu(op, w);
    #1;
    chk(acc_value, e);
    chk(tmp_value, t);
    chk(program_status_word, {8'h00, c});
  endtask : run
  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(program_status_word, 16'h0030);
    foreach (rows[i])
      run(rows[i].op, 1'b0, rows[i].p, {8'h12, rows[i].a}, {8'h00, rows[i].t}, {8'h12, rows[i].e}, rows[i].c);
    run(CPUSF_OP_ADD, 1'b1, 8'h00, 16'h7fff, 16'h0001, 16'h8000, 8'h8a);
    // Top bank, interrupts on, mask at level 2.
    @(posedge clock);
    gp_reg_index <= 3'h7;
    mem_addr <= 16'hffff;
    bus(1'b1, 8'h00, 16'h1f60);
    bus(1'b0, 8'h00, 16'h0000);
    #1;
    chk(q, 32'h00001f60);
    chk(gp_reg_addr, 16'h01ff);
    chk(mem_region, CPUSF_REGION_PROG);
    @(posedge clock);
    irq_request <= 1'b1;
    mem_addr <= 16'h0080;
    for (int l = 0; l < 4; l++) begin
      irq_level <= l[1:0];
      @(negedge clock);
      chk(irq_accept, l < 2);
      @(posedge clock);
    end
    irq_level <= 2'h0;
    #1;
    chk(mem_region, CPUSF_REGION_DATA);
    bus(1'b0, 8'h1c, 16'h0000);
    chk(q, 32'h00000003);
    // Lowest mask level still admits a level one request.
    bus(1'b1, 8'h00, 16'h0070);
    #1;
    chk(irq_accept, 1'b1);
    bus(1'b1, 8'h00, 16'h1f20);
    #1;
    chk(irq_accept, 1'b0);
    @(posedge clock);
    pc_load_value <= 16'hffff;
    pc_load <= 1'b1;
    @(posedge clock);
    pc_load <= 1'b0;
    pc_inc <= 1'b1;
    @(posedge clock);
    pc_inc <= 1'b0;
    #1;
    chk(pc_value, 16'h0000);
    // With the clock enable low nothing may move, not even a pending increment.
    @(posedge clock);
    clk_en <= 1'b0;
    pc_inc <= 1'b1;
    repeat (2) @(posedge clock);
    clk_en <= 1'b1;
    pc_inc <= 1'b0;
    #1;
    chk(pc_value, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h10 + 8'(4 * i), 16'ha5c3 ^ 16'(i));
      bus(1'b0, 8'h10 + 8'(4 * i), 16'h0000);
      chk(q, {16'h0000, 16'ha5c3 ^ 16'(i)});
    end
    #1;
    chk(sp_value, 16'ha5c1);
    chk(index_register, 16'ha5c3);
    chk(extra_pointer, 16'ha5c2);
    // A reset in mid-run must drop the interrupt enable again.
    bus(1'b1, 8'h00, 16'h0040);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    chk(program_status_word, 16'h0030);
    bus(1'b0, 8'h20, 16'h0000);
    chk(q, 32'h00000000);
    final_report();
  end
endmodule : cpu_status_flags_datapath_test
